// [btc_bank.sv]
/*
  Register bank for the second buck regulator: run and idle mode and
  voltage codes, and turn-on / turn-off delays with their sequence timer.
  Assumes a byte-wide register port from the serial front end, a preload
  strobe from the non-volatile loader, and single-cycle sequence starts.
*/
// Operation
// R1 - Run mode from bits 5:4: 00 automatic, 01 forced fixed, 1x reserved.
// R2 - Run voltage code 4 bits, 1.1 V plus 50 mV per step, resets 0010.
// R3 - Idle mode uses same encoding in its own field, resets 00.
// R4 - Idle voltage code 4 bits, same scale, resets 0010.
// R5 - On/off delays 7 bits, 1 ms per code from sequence start; reset 3, 59.
// R6 - Host never writes reserved mode codes, writes zero to unused bits.
`timescale 1ns/1ps
module btc_bank
  import btc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic nvm_load,
  input wire logic [31:0] nvm_data,
  input wire logic sleep_state,
  input wire logic seq_up_start,
  input wire logic seq_down_start,
  output logic [1:0] regulator_two_switching_sel,
  output logic [3:0] regulator_two_voltage_code,
  output logic regulator_two_enable
);
  import btc_pkg::*;

  typedef struct packed {
    logic [7:0] act;
    logic [7:0] slp;
    logic [7:0] on_dly;
    logic [7:0] off_dly;
    logic [7:0] rdata;
    logic [1:0] sel;
    logic [3:0] vcode;
    logic en;
    logic going_up;
    logic sleep_s1;
    logic sleep_s2;
  } btc_state_t;

  btc_state_t cur_ff, nxt_cur;
  logic tmr_done;
  logic [6:0] tmr_code;
  logic tmr_start;
  logic [1:0] regulator_two_run_switching_sel;
  logic [3:0] regulator_two_run_voltage_code;
  logic [1:0] regulator_two_idle_switching_sel;
  logic [3:0] regulator_two_idle_voltage_code;
  logic [6:0] regulator_two_turn_on_wait;
  logic [6:0] regulator_two_turn_off_wait;

  assign regulator_two_run_switching_sel = cur_ff.act[BTC_MODE_LSB +: 2]; // [R1]
  assign regulator_two_run_voltage_code = cur_ff.act[BTC_VCODE_LSB +: 4]; // [R2]
  assign regulator_two_idle_switching_sel = cur_ff.slp[BTC_MODE_LSB +: 2]; // [R3]
  assign regulator_two_idle_voltage_code = cur_ff.slp[BTC_VCODE_LSB +: 4]; // [R4]
  assign regulator_two_turn_on_wait = cur_ff.on_dly[BTC_DLY_LSB +: 7]; // [R5]
  assign regulator_two_turn_off_wait = cur_ff.off_dly[BTC_DLY_LSB +: 7]; // [R5]

  assign tmr_start = seq_up_start | seq_down_start;
  assign tmr_code = seq_up_start ? regulator_two_turn_on_wait :
    (seq_down_start ? regulator_two_turn_off_wait :
    (cur_ff.going_up ? regulator_two_turn_on_wait : regulator_two_turn_off_wait));

  btc_delay_timer u_tmr (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .start(tmr_start),
    .abort(tmr_start),
    .wait_code(tmr_code),
    .done(tmr_done)
  );

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.sleep_s1 = sleep_state;
    nxt_cur.sleep_s2 = cur_ff.sleep_s1;
    // Preload first so a host write in the same cycle takes the last word
    if (nvm_load) begin
      nxt_cur.act = nvm_data[7:0];
      nxt_cur.slp = nvm_data[15:8];
      nxt_cur.on_dly = nvm_data[23:16];
      nxt_cur.off_dly = nvm_data[31:24];
    end
    // Unused bits are stored as written; the host keeps them at zero [R6]
    if (reg_wr) begin
      if (reg_addr == BTC_ACTIVE_OFS) begin
        nxt_cur.act = reg_wdata;
      end else if (reg_addr == BTC_SLEEP_OFS) begin
        nxt_cur.slp = reg_wdata;
      end else if (reg_addr == BTC_ON_DLY_OFS) begin
        nxt_cur.on_dly = reg_wdata;
      end else if (reg_addr == BTC_OFF_DLY_OFS) begin
        nxt_cur.off_dly = reg_wdata;
      end
    end
    if (reg_addr == BTC_ACTIVE_OFS) begin
      nxt_cur.rdata = cur_ff.act;
    end else if (reg_addr == BTC_SLEEP_OFS) begin
      nxt_cur.rdata = cur_ff.slp;
    end else if (reg_addr == BTC_ON_DLY_OFS) begin
      nxt_cur.rdata = cur_ff.on_dly;
    end else if (reg_addr == BTC_OFF_DLY_OFS) begin
      nxt_cur.rdata = cur_ff.off_dly;
    end else begin
      nxt_cur.rdata = 8'h00;
    end
    // State-dependent operating point, sleep level synchronised
    if (cur_ff.sleep_s2) begin
      nxt_cur.sel = regulator_two_idle_switching_sel; // [R3]
      nxt_cur.vcode = regulator_two_idle_voltage_code; // [R4]
    end else begin
      nxt_cur.sel = regulator_two_run_switching_sel; // [R1]
      nxt_cur.vcode = regulator_two_run_voltage_code; // [R2]
    end
    // Reserved modes fall back to automatic so the stage never sees them
    if (nxt_cur.sel[1]) begin
      nxt_cur.sel = BTC_AUTOMATIC_SWITCHING; // [R1] [R3]
    end
    if (seq_up_start) begin
      nxt_cur.going_up = 1'b1;
    end else if (seq_down_start) begin
      nxt_cur.going_up = 1'b0;
    end
    if (tmr_done && !tmr_start) begin
      nxt_cur.en = cur_ff.going_up; // [R5]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cur_ff <= '{act: BTC_ACTIVE_RST, slp: BTC_SLEEP_RST, on_dly: BTC_ON_DLY_RST,
                  off_dly: BTC_OFF_DLY_RST, rdata: 8'h00, sel: BTC_AUTOMATIC_SWITCHING,
                  vcode: BTC_ACTIVE_RST[3:0], en: 1'b0, going_up: 1'b0,
                  sleep_s1: 1'b0, sleep_s2: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign reg_rdata = cur_ff.rdata;
  assign regulator_two_switching_sel = cur_ff.sel;
  assign regulator_two_voltage_code = cur_ff.vcode;
  assign regulator_two_enable = cur_ff.en;

  chk_mode_not_reserved: assert property (@(posedge core_clk) disable iff (!rst_b) // [R1]
    !regulator_two_switching_sel[1]) else $error("reserved switching mode driven");

  chk_run_point_follow: assert property (@(posedge core_clk) disable iff (!rst_b) // [R2]
    (!cur_ff.sleep_s2 && !cur_ff.act[5]) |=> (regulator_two_voltage_code ==
    $past(cur_ff.act[3:0]))) else $error("run voltage code not applied");

  chk_run_mode_follow: assert property (@(posedge core_clk) disable iff (!rst_b) // [R1]
    (!cur_ff.sleep_s2 && !cur_ff.act[5]) |=> (regulator_two_switching_sel ==
    $past(cur_ff.act[5:4]))) else $error("run mode not applied");

  chk_idle_mode_follow: assert property (@(posedge core_clk) disable iff (!rst_b) // [R3]
    (cur_ff.sleep_s2 && !cur_ff.slp[5]) |=> (regulator_two_switching_sel ==
    $past(cur_ff.slp[5:4]))) else $error("idle mode not applied");

  // Reserved codes can still arrive from the preload word, only the host avoids them
  chk_reserved_fallback: assert property (@(posedge core_clk) disable iff (!rst_b) // [R1] [R3]
    (cur_ff.sleep_s2 ? cur_ff.slp[5] : cur_ff.act[5]) |=>
    (regulator_two_switching_sel == BTC_AUTOMATIC_SWITCHING)) else $error("reserved mode kept");

  chk_idle_volt_follow: assert property (@(posedge core_clk) disable iff (!rst_b) // [R4]
    cur_ff.sleep_s2 |=> (regulator_two_voltage_code == $past(cur_ff.slp[3:0])))
    else $error("idle voltage code not applied");

  sequence sleep_entry_s;
    $rose(sleep_state) ##1 sleep_state [*2];
  endsequence

  // Two synchroniser stages plus the output register: three edges of lag
  chk_sleep_point_lag: assert property (@(posedge core_clk) disable iff (!rst_b) // [R4]
    sleep_entry_s |=> (regulator_two_voltage_code == $past(cur_ff.slp[3:0])))
    else $error("idle point late after sleep entry");

  chk_reset_values: assert property (@(posedge core_clk) // [R2] [R4] [R5]
    $rose(rst_b) |-> (cur_ff.on_dly == 8'h03 && cur_ff.off_dly == 8'h3b &&
    cur_ff.act == 8'h02 && cur_ff.slp == 8'h02)) else $error("bad reset values");

  chk_preload_lands: assert property (@(posedge core_clk) disable iff (!rst_b) // [R2] [R5]
    (nvm_load && !reg_wr) |=> (cur_ff.act == $past(nvm_data[7:0]) &&
    cur_ff.slp == $past(nvm_data[15:8]) && cur_ff.on_dly == $past(nvm_data[23:16]) &&
    cur_ff.off_dly == $past(nvm_data[31:24]))) else $error("preload lost");

  sequence up_zero_s;
    seq_up_start && regulator_two_turn_on_wait == 7'h0;
  endsequence

  chk_zero_delay_on: assert property (@(posedge core_clk) disable iff (!rst_b) // [R5]
    up_zero_s ##1 !tmr_start [*3] |-> regulator_two_enable)
    else $error("zero delay turn on late");

  sequence down_zero_s;
    seq_down_start && !seq_up_start && regulator_two_turn_off_wait == 7'h0;
  endsequence

  chk_zero_delay_off: assert property (@(posedge core_clk) disable iff (!rst_b) // [R5]
    down_zero_s ##1 !tmr_start [*3] |-> !regulator_two_enable)
    else $error("zero delay turn off late");

  chk_on_not_early: assert property (@(posedge core_clk) disable iff (!rst_b) // [R5]
    (seq_up_start && regulator_two_turn_on_wait != 7'h0 && !regulator_two_enable)
    |=> !regulator_two_enable [*8]) else $error("turn on before delay");

  chk_enable_holds: assert property (@(posedge core_clk) disable iff (!rst_b) // [R5]
    (!tmr_done || tmr_start) |=> $stable(regulator_two_enable))
    else $error("enable moved without delay end");

  chk_write_lands: assert property (@(posedge core_clk) disable iff (!rst_b) // [R5]
    (reg_wr && !nvm_load && reg_addr == BTC_ON_DLY_OFS) |=>
    (cur_ff.on_dly == $past(reg_wdata))) else $error("write lost");

  chk_write_act_lands: assert property (@(posedge core_clk) disable iff (!rst_b) // [R1] [R2]
    (reg_wr && !nvm_load && reg_addr == BTC_ACTIVE_OFS) |=>
    (cur_ff.act == $past(reg_wdata))) else $error("run setting write lost");

  chk_read_back: assert property (@(posedge core_clk) disable iff (!rst_b) // [R3]
    (!reg_wr && !nvm_load && reg_addr == BTC_SLEEP_OFS) ##1 (reg_addr == BTC_SLEEP_OFS)
    |-> (reg_rdata == cur_ff.slp)) else $error("read back mismatch");
endmodule

// [btc_pkg.sv]
/*
  Constants for the second buck regulator's two-state configuration bank:
  register offsets, field positions, reset values, mode codes and timing.
  Assumes an 8-bit register access port driven by the serial front end.
*/
package btc_pkg;
  localparam logic [7:0] BTC_ACTIVE_OFS = 8'h28;
  localparam logic [7:0] BTC_SLEEP_OFS = 8'h29;
  localparam logic [7:0] BTC_ON_DLY_OFS = 8'h2a;
  localparam logic [7:0] BTC_OFF_DLY_OFS = 8'h2b;
  localparam logic [7:0] BTC_ACTIVE_RST = 8'h02;
  localparam logic [7:0] BTC_SLEEP_RST = 8'h02;
  localparam logic [7:0] BTC_ON_DLY_RST = 8'h03;
  localparam logic [7:0] BTC_OFF_DLY_RST = 8'h3b;
  localparam int BTC_MODE_LSB = 4;
  localparam int BTC_VCODE_LSB = 0;
  localparam int BTC_DLY_LSB = 0;
  localparam logic [1:0] BTC_AUTOMATIC_SWITCHING = 2'h0;
  localparam logic [1:0] BTC_FORCED_FIXED_SWITCHING = 2'h1;
  // Each delay code step is one millisecond
  localparam int BTC_CLK_PERIOD_PS = 5000;
  localparam int BTC_STEP_MS = 1;
  localparam logic [17:0] BTC_CYC_PER_MS =
    18'(BTC_STEP_MS * 1000000000 / BTC_CLK_PERIOD_PS);
  typedef enum logic [1:0] {BTC_IDLE, BTC_WAIT, BTC_DONE} btc_seq_t;
endpackage

// [btc_delay_timer.sv]
/*
  Millisecond delay timer for one sequence step. Counts ms ticks from the
  start pulse until the programmed code is reached, then raises done.
  Assumes start is a single-cycle pulse on core_clk.
*/
`timescale 1ns/1ps
module btc_delay_timer
  import btc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic abort,
  input wire logic [6:0] wait_code,
  output logic done
);
  typedef struct packed {
    btc_seq_t st;
    logic [17:0] sub;
    logic [6:0] ms;
    logic done;
  } btc_tmr_t;

  btc_tmr_t cur_ff, nxt_cur;

  always_comb begin
    nxt_cur = cur_ff;
    case (cur_ff.st)
      BTC_IDLE: begin
        nxt_cur.done = 1'b0;
        if (start) begin
          nxt_cur.st = BTC_WAIT;
          nxt_cur.sub = '0;
          nxt_cur.ms = '0;
        end
      end
      BTC_WAIT: begin
        // Code 0 ends at once, code n after n full milliseconds
        if (cur_ff.ms == wait_code) begin
          nxt_cur.st = BTC_DONE;
          nxt_cur.done = 1'b1;
        end else if (cur_ff.sub == BTC_CYC_PER_MS - 18'h1) begin
          nxt_cur.sub = '0;
          nxt_cur.ms = cur_ff.ms + 7'h1;
        end else begin
          nxt_cur.sub = cur_ff.sub + 18'h1;
        end
      end
      default: begin
        nxt_cur.done = 1'b1;
      end
    endcase
    if (abort) begin
      nxt_cur.st = BTC_IDLE;
      nxt_cur.done = 1'b0;
    end
    // Start overrides abort so a pulse on both restarts the count from any state
    if (start) begin
      nxt_cur.st = BTC_WAIT;
      nxt_cur.sub = '0;
      nxt_cur.ms = '0;
      nxt_cur.done = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cur_ff <= '{st: BTC_IDLE, sub: '0, ms: '0, done: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign done = cur_ff.done;
endmodule

// [btc_host_model.sv]
/*
  Behavioural host on the byte register port: one write or read at a time.
  Assumes the bank answers a read on the edge after the address settles.
*/
`timescale 1ns/1ps
module btc_host_model (
  input wire logic core_clk,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic rd_valid
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    rd_valid = 1'b0;
  end
  // Callers keep mode codes legal and unused bits zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    // Released data shows junk so a stale byte cannot pass
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    @(posedge core_clk);
    rd_valid <= 1'b1;
    @(posedge core_clk);
    rd_valid <= 1'b0;
  endtask
endmodule

// [testbench.sv]
/*
  Self-checking bench for the buck two-state bank; a watcher compares reads.
  Assumes btc_pkg, btc_bank and btc_host_model are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  logic core_clk;
  logic rst_b;
  logic reg_wr;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic nvm_load;
  logic [31:0] nvm_data;
  logic sleep_state;
  logic seq_up_start;
  logic seq_down_start;
  logic [1:0] sel;
  logic [3:0] vcode;
  logic enable;
  logic rd_valid;
  logic [14:0] notes[$];
  logic [7:0] mirror[4];
  logic exp_en;
  int n_mismatch;
  int checks;
  btc_bank u_btc_bank (.core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .nvm_load(nvm_load), .nvm_data(nvm_data), .sleep_state(sleep_state),
    .seq_up_start(seq_up_start), .seq_down_start(seq_down_start),
    .regulator_two_switching_sel(sel), .regulator_two_voltage_code(vcode),
    .regulator_two_enable(enable));
  btc_host_model u_host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .rd_valid(rd_valid));
  function automatic logic [14:0] expect_of(input logic [7:0] a);
    logic [7:0] r;
    logic [7:0] d;
    r = mirror[sleep_state];
    d = (a >= 8'h28 && a <= 8'h2b) ? mirror[a[1:0]] : 8'h00;
    // Reserved modes read back as stored but drive automatic switching
    return {exp_en, (r[5] ? 2'h0 : r[5:4]), r[3:0], d};
  endfunction
  task automatic chk(input logic [7:0] a);
    notes.push_back(expect_of(a));
    u_host.rd(a);
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    u_host.wr(a, d);
    if (a >= 8'h28 && a <= 8'h2b) mirror[a[1:0]] = d;
  endtask
  task automatic pulse(input logic up, input logic dn, input logic en);
    seq_up_start <= up;
    seq_down_start <= dn;
    @(posedge core_clk);
    seq_up_start <= 1'b0;
    seq_down_start <= 1'b0;
    exp_en = en;
    repeat (20) @(posedge core_clk);
    chk(8'h2b);
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    if (rd_valid === 1'b1) begin
      checks++;
      if (notes.size() == 0 ||
          {enable, sel, vcode, reg_rdata} !== notes[0]) begin
        n_mismatch++;
        $display("BAD %0t read gave %h", $time, {enable, sel, vcode, reg_rdata});
      end
      if (notes.size() != 0) void'(notes.pop_front());
    end
  end
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    rst_b = 1'b0;
    nvm_load = 1'b0;
    nvm_data = 32'h0000_0000;
    sleep_state = 1'b0;
    seq_up_start = 1'b0;
    seq_down_start = 1'b0;
    mirror = '{8'h02, 8'h02, 8'h03, 8'h3b};
    exp_en = 1'b0;
    void'($urandom(32'h02ac));
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) chk(8'h28 + 8'(i));
    put(8'h2c, 8'h5a);
    chk(8'h2c);
    for (int i = 0; i < 8; i++) begin
      put(8'h28, {3'h0, 1'($urandom), 4'($urandom)});
      put(8'h29, {3'h0, 1'($urandom), 4'($urandom)});
      sleep_state <= 1'($urandom);
      repeat (4) @(posedge core_clk);
      chk(8'h28);
      chk(8'h29);
    end
    put(8'h28, 8'h17);
    put(8'h29, 8'h1a);
    repeat (4) @(posedge core_clk);
    chk(8'h28);
    nvm_data <= $urandom;
    nvm_load <= 1'b1;
    @(posedge core_clk);
    nvm_load <= 1'b0;
    mirror = '{nvm_data[7:0], nvm_data[15:8], nvm_data[23:16], nvm_data[31:24]};
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 4; i++) chk(8'h28 + 8'(i));
    put(8'h2a, 8'h7f);
    put(8'h2b, 8'h00);
    chk(8'h2a);
    put(8'h2a, 8'h00);
    pulse(1'b1, 1'b0, 1'b1);
    pulse(1'b0, 1'b1, 1'b0);
    pulse(1'b1, 1'b1, 1'b1);
    put(8'h2a, 8'h01);
    pulse(1'b0, 1'b1, 1'b0);
    pulse(1'b1, 1'b0, 1'b0);
    @(posedge core_clk);
    end_of_test();
  end
endmodule
